/* shared/ocl_map.svh */
// ocl_map.svh: offsets, field positions, link constants and timing figures
// of the configuration loader and output gate.
// assumes: included by bare name; definitions only.
`ifndef OCL_MAP_SVH
`define OCL_MAP_SVH

// core clock and time base
`define OCL_CLK_MHZ 200
`define OCL_TICK_US 1000

// intervals in milliseconds
`define OCL_POR_MS 25
`define OCL_TMR_STEP_MS 10
`define OCL_WATCH_MS 1000
`define OCL_LINK_TO_MS 28

// byte addresses on the register bus
`define OCL_ADDR_SECOND_CONFIG_REGISTER 8'h00
`define OCL_ADDR_SOFTWARE_CONTROL_REGISTER 8'h04
`define OCL_ADDR_OUTPUT_TIMER_REGISTER 8'h08
`define OCL_ADDR_STATUS 8'h0C
`define OCL_ADDR_PTR_BASE 8'h10
`define OCL_ADDR_OTP_PROG 8'h20
`define OCL_ADDR_LINK 8'h24
`define OCL_ADDR_RAM_BASE 8'h40

// second_config_register fields
`define OCL_CFG_LINK_DIS 0
`define OCL_CFG_INSTANT 1

// otp programming word fields
`define OCL_PROG_BANK_LSB 16
`define OCL_PROG_WORD_LSB 8

// status register fields
`define OCL_ST_OUT_EN 0
`define OCL_ST_STATE_LSB 2
`define OCL_ST_RAM_OK 5
`define OCL_ST_BANK_LSB 8

// pointer register programmed flag
`define OCL_PTR_DONE 7

// single-wire link
`define OCL_INIT_BYTE 8'h55
`define OCL_CMD_RD_BIT 7
`define OCL_LINK_ADR_SOFTWARE_CONTROL_REGISTER 4'h1
`define OCL_LINK_ADR_OUTPUT_TIMER_REGISTER 4'h2

// checksum: all words of a bank, checksum byte included, add to this
`define OCL_CHK_TARGET 8'hFF

`endif

/* shared/ocl_pkg.sv */
// ocl_pkg: state types of the configuration loader and output gate.
// assumes: compiled before every design file.
package ocl_pkg;

  typedef enum logic [2:0] {
    ST_POR_WAIT,
    ST_POR_LOAD,
    ST_RUN,
    ST_TIMED,
    ST_WATCH
  } ocl_state_e;

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_MEAS,
    LK_GAP,
    LK_START,
    LK_BITS
  } ocl_link_e;

endpackage

/* hw/ocl_timebase.sv */
// ocl_timebase: prescaler that turns the core clock into a millisecond tick.
// assumes: one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ocl_timebase #(
  parameter int CYCLES = 200000
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // tick
  output logic o_tick
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] pre_cnt;

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      pre_cnt <= '0;
      o_tick <= 1'b0;
    end
    else if (pre_cnt == CW'(CYCLES - 1))
    begin
      pre_cnt <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      pre_cnt <= pre_cnt + 1'b1;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* hw/ocl_loader.sv */
// ocl_loader: power-on configuration loader, one-time-programmable banks,
// single-wire receiver and timed sensor-output gate.
// assumes: Avalon-MM master on the core clock; single-wire pin already
// synchronous to the core clock; i_supply_ok from a supply monitor.
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"

module ocl_loader import ocl_pkg::*; #(
  parameter int TICK_CYCLES = `OCL_TICK_US * `OCL_CLK_MHZ,
  parameter int WORDS = 8,
  parameter int BAUD_W = 18
) (
  // clock, reset and supply monitor
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_supply_ok,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // single-wire pin, open drain
  input wire logic i_single_wire_pin,
  output logic o_single_wire_out,
  output logic o_single_wire_oe,
  // sensor output gate
  output logic o_sensor_output_en
);

  localparam int NBANK = 7;
  localparam int NPTR = 4;
  localparam int WW = $clog2(WORDS);
  localparam logic [9:0] POR_T = 10'(`OCL_POR_MS * 1000 / `OCL_TICK_US);
  localparam logic [9:0] STEP_T = 10'(`OCL_TMR_STEP_MS * 1000 / `OCL_TICK_US);
  localparam logic [9:0] WATCH_T = 10'(`OCL_WATCH_MS * 1000 / `OCL_TICK_US);
  localparam logic [5:0] LINK_TO_T = 6'(`OCL_LINK_TO_MS * 1000 / `OCL_TICK_US);

  logic rst;
  logic tick;
  logic [WORDS-1:0][7:0] ram;
  logic [WORDS-1:0][7:0] otp_mem [NBANK];
  logic [WORDS-1:0] otp_done [NBANK];
  logic [2:0] ptr [NPTR];
  logic [NPTR-1:0] ptr_done;
  logic [2:0] ram_source_select;
  logic [7:0] output_on_timer;
  logic [2:0] active_bank;
  logic [9:0] tcnt;
  ocl_state_e st;

  // supply loss acts as reset on everything but the nonvolatile cells
  assign rst = i_sys_rst | ~i_supply_ok;

  ocl_timebase #(
    .CYCLES(TICK_CYCLES)
  ) u_timebase (
    .i_core_clk(i_core_clk),
    .i_sys_rst(rst),
    .o_tick(tick)
  );

  function automatic logic [7:0] sum8(input logic [WORDS-1:0][7:0] v);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < WORDS; k++)
      s = s + v[k];
    return s;
  endfunction

  // highest programmed pointer wins since the scan overwrites upward
  function automatic logic [2:0] scan_ptr(input logic [NPTR-1:0] dn, input logic [2:0] p0,
                                          input logic [2:0] p1, input logic [2:0] p2, input logic [2:0] p3);
    logic [2:0] b;
    b = 3'h0;
    if (dn[0] && p0 != 3'h0) b = p0;
    if (dn[1] && p1 != 3'h0) b = p1;
    if (dn[2] && p2 != 3'h0) b = p2;
    if (dn[3] && p3 != 3'h0) b = p3;
    return b;
  endfunction

  // bus
  logic bus_req;
  logic bus_wr_go;
  logic [7:0] wa;
  logic [7:0] wdat;
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_wr_go = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  assign wa = i_avs_address;
  assign wdat = i_avs_writedata[7:0];

  // one wait cycle per access; the read word is latched in that cycle
  always_ff @(posedge i_core_clk)
  begin
    if (rst)
      o_avs_waitrequest <= 1'b1;
    else if (bus_req && o_avs_waitrequest)
      o_avs_waitrequest <= 1'b0;
    else
      o_avs_waitrequest <= 1'b1;
  end

  // link receiver state
  ocl_link_e lk_st;
  logic [BAUD_W-1:0] lk_bitlen;
  logic [BAUD_W-1:0] lk_cnt;
  logic [3:0] lk_bit;
  logic [7:0] lk_sh;
  logic [1:0] lk_idx;
  logic [7:0] lk_cmd;
  logic [7:0] lk_last;
  logic [5:0] lk_to;
  logic pin_q;
  logic lk_en;
  logic lk_done;
  logic lk_wr;
  logic activity;

  assign lk_en = ~ram[0][`OCL_CFG_LINK_DIS] & ~o_sensor_output_en;
  assign lk_done = (lk_st == LK_BITS) && (lk_cnt == lk_bitlen - 1'b1) && (lk_bit == 4'd8) && i_single_wire_pin;
  assign lk_wr = lk_done && (lk_idx == 2'd2) && ~lk_cmd[`OCL_CMD_RD_BIT];
  assign activity = (i_single_wire_pin != pin_q) & ~o_sensor_output_en;

  always_ff @(posedge i_core_clk)
  begin
    if (rst)
      pin_q <= 1'b1;
    else
      pin_q <= i_single_wire_pin;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (rst || !lk_en)
    begin
      lk_st <= LK_IDLE;
      lk_bitlen <= '0;
      lk_cnt <= '0;
      lk_bit <= 4'h0;
      lk_sh <= 8'h00;
      lk_idx <= 2'd0;
      lk_cmd <= 8'h00;
      lk_last <= 8'h00;
      lk_to <= 6'd0;
    end
    else
    begin
      if (lk_st == LK_IDLE || lk_done)
        lk_to <= 6'd0;
      else if (tick)
        lk_to <= lk_to + 1'b1;
      if (lk_st != LK_IDLE && tick && lk_to == LINK_TO_T - 1'b1)
        lk_st <= LK_IDLE;
      else
      begin
        case (lk_st)
          LK_IDLE:
          begin
            lk_idx <= 2'd0;
            lk_cnt <= {{(BAUD_W-1){1'b0}}, 1'b1};
            if (!i_single_wire_pin)
              lk_st <= LK_MEAS;
          end
          LK_MEAS:
          begin
            // the start bit of the init byte is exactly one bit period
            if (i_single_wire_pin)
            begin
              lk_bitlen <= lk_cnt;
              lk_cnt <= lk_cnt >> 1;
              lk_bit <= 4'h0;
              lk_st <= LK_BITS;
            end
            else if (&lk_cnt)
              lk_st <= LK_IDLE;
            else
              lk_cnt <= lk_cnt + 1'b1;
          end
          LK_GAP:
          begin
            lk_cnt <= '0;
            if (!i_single_wire_pin)
              lk_st <= LK_START;
          end
          LK_START:
          begin
            if (lk_cnt == (lk_bitlen >> 1))
            begin
              lk_cnt <= '0;
              lk_bit <= 4'h0;
              lk_st <= i_single_wire_pin ? LK_GAP : LK_BITS;
            end
            else
              lk_cnt <= lk_cnt + 1'b1;
          end
          LK_BITS:
          begin
            if (lk_cnt == lk_bitlen - 1'b1)
            begin
              lk_cnt <= '0;
              if (lk_bit != 4'd8)
              begin
                lk_sh <= {i_single_wire_pin, lk_sh[7:1]};
                lk_bit <= lk_bit + 1'b1;
              end
              else if (!i_single_wire_pin)
                lk_st <= LK_IDLE;
              else
              begin
                lk_last <= lk_sh;
                lk_st <= LK_GAP;
                case (lk_idx)
                  2'd0:
                  begin
                    if (lk_sh != `OCL_INIT_BYTE)
                      lk_st <= LK_IDLE;
                    lk_idx <= 2'd1;
                  end
                  2'd1:
                  begin
                    lk_cmd <= lk_sh;
                    lk_idx <= 2'd2;
                  end
                  default:
                    lk_idx <= 2'd3;
                endcase
              end
            end
            else
              lk_cnt <= lk_cnt + 1'b1;
          end
          default:
            lk_st <= LK_IDLE;
        endcase
      end
    end
  end

  // register writes from bus or link
  logic software_control_register_wr;
  logic output_timer_register_wr;
  logic [7:0] wr_val;
  assign software_control_register_wr = (bus_wr_go && wa == `OCL_ADDR_SOFTWARE_CONTROL_REGISTER) || (lk_wr && lk_cmd[3:0] == `OCL_LINK_ADR_SOFTWARE_CONTROL_REGISTER);
  assign output_timer_register_wr = (bus_wr_go && wa == `OCL_ADDR_OUTPUT_TIMER_REGISTER) || (lk_wr && lk_cmd[3:0] == `OCL_LINK_ADR_OUTPUT_TIMER_REGISTER);
  assign wr_val = lk_wr ? lk_sh : wdat;

  always_ff @(posedge i_core_clk)
  begin
    if (rst)
      ram_source_select <= 3'h0;
    else if (software_control_register_wr)
      ram_source_select <= wr_val[2:0];
  end

  // bank selection and checks
  logic [2:0] ptr_bank;
  logic ptr_ok;
  logic ram_ok;
  logic instant;
  logic watch_done;
  logic fsm_load;
  logic swl_load;
  logic load_go;
  logic [2:0] load_idx;

  assign ptr_bank = scan_ptr(ptr_done, ptr[0], ptr[1], ptr[2], ptr[3]);
  assign ptr_ok = (ptr_bank != 3'h0) && (sum8(otp_mem[ptr_bank - 3'h1]) == `OCL_CHK_TARGET);
  assign ram_ok = sum8(ram) == `OCL_CHK_TARGET;
  assign instant = ptr_ok && otp_mem[ptr_bank - 3'h1][0][`OCL_CFG_INSTANT];
  assign watch_done = (st == ST_WATCH) && !output_timer_register_wr && !activity && tick && (tcnt == WATCH_T - 1'b1);
  assign fsm_load = ((st == ST_POR_LOAD) || (watch_done && !ram_ok)) && ptr_ok;
  assign swl_load = software_control_register_wr && (wr_val[2:0] != 3'h0);
  assign load_go = swl_load | fsm_load;
  assign load_idx = swl_load ? wr_val[2:0] - 3'h1 : ptr_bank - 3'h1;

  // working RAM; word 0 is the second_config_register
  for (genvar i = 0; i < WORDS; i++)
  begin : g_ram
    always_ff @(posedge i_core_clk)
    begin
      if (rst)
        ram[i] <= 8'h00;
      else if (load_go)
        ram[i] <= otp_mem[load_idx][i];
      else if (bus_wr_go && (wa == 8'(`OCL_ADDR_RAM_BASE + 4 * i) || (i == 0 && wa == `OCL_ADDR_SECOND_CONFIG_REGISTER)))
        ram[i] <= wdat;
    end
  end

  // nonvolatile cells: cleared only by the system reset, never by supply loss
  logic prog_go;
  logic [2:0] prog_bank;
  logic [WW-1:0] prog_word;
  assign prog_go = i_avs_write && !o_avs_waitrequest && (wa == `OCL_ADDR_OTP_PROG) && (&i_avs_byteenable);
  assign prog_bank = i_avs_writedata[`OCL_PROG_BANK_LSB +: 3];
  assign prog_word = i_avs_writedata[`OCL_PROG_WORD_LSB +: WW];

  for (genvar b = 0; b < NBANK; b++)
  begin : g_otp
    always_ff @(posedge i_core_clk)
    begin
      if (i_sys_rst)
      begin
        otp_mem[b] <= '0;
        otp_done[b] <= '0;
      end
      else if (prog_go && prog_bank == 3'(b) && !otp_done[b][prog_word])
      begin
        otp_mem[b][prog_word] <= wdat;
        otp_done[b][prog_word] <= 1'b1;
      end
    end
  end

  for (genvar n = 0; n < NPTR; n++)
  begin : g_ptr
    always_ff @(posedge i_core_clk)
    begin
      if (i_sys_rst)
      begin
        ptr[n] <= 3'h0;
        ptr_done[n] <= 1'b0;
      end
      else if (bus_wr_go && wa == 8'(`OCL_ADDR_PTR_BASE + 4 * n) && !ptr_done[n]
               && (n == 0 || ptr_done[(n == 0) ? 0 : n - 1]) && wdat[2:0] != 3'h0)
      begin
        ptr[n] <= wdat[2:0];
        ptr_done[n] <= 1'b1;
      end
    end
  end

  // power-on sequence and output gate
  always_ff @(posedge i_core_clk)
  begin
    if (rst)
    begin
      st <= ST_POR_WAIT;
      o_sensor_output_en <= 1'b0;
      output_on_timer <= 8'h00;
      tcnt <= 10'd0;
      active_bank <= 3'h0;
    end
    else
    begin
      if (swl_load)
        active_bank <= wr_val[2:0];
      if (output_timer_register_wr && st != ST_POR_WAIT && st != ST_POR_LOAD)
      begin
        tcnt <= 10'd0;
        output_on_timer <= wr_val;
        if (wr_val != 8'h00)
        begin
          o_sensor_output_en <= 1'b1;
          st <= ST_TIMED;
        end
        else if (st == ST_TIMED)
        begin
          o_sensor_output_en <= 1'b0;
          st <= ST_WATCH;
        end
      end
      else
      begin
        case (st)
          ST_POR_WAIT:
          begin
            if (instant || (tick && tcnt == POR_T - 1'b1))
            begin
              tcnt <= 10'd0;
              st <= ST_POR_LOAD;
            end
            else if (tick)
              tcnt <= tcnt + 1'b1;
          end
          ST_POR_LOAD:
          begin
            o_sensor_output_en <= ptr_ok;
            if (!swl_load)
              active_bank <= ptr_ok ? ptr_bank : 3'h0;
            st <= ST_RUN;
          end
          ST_RUN:
            tcnt <= 10'd0;
          ST_TIMED:
          begin
            if (tick && tcnt == STEP_T - 1'b1)
            begin
              tcnt <= 10'd0;
              if (output_on_timer == 8'h01)
              begin
                o_sensor_output_en <= 1'b0;
                st <= ST_WATCH;
              end
              output_on_timer <= output_on_timer - 8'h01;
            end
            else if (tick)
              tcnt <= tcnt + 1'b1;
          end
          ST_WATCH:
          begin
            if (activity)
              tcnt <= 10'd0;
            else if (watch_done)
            begin
              tcnt <= 10'd0;
              st <= ST_RUN;
              o_sensor_output_en <= ram_ok | ptr_ok;
              if (!ram_ok && ptr_ok && !swl_load)
                active_bank <= ptr_bank;
            end
            else if (tick)
              tcnt <= tcnt + 1'b1;
          end
          default:
            st <= ST_POR_WAIT;
        endcase
      end
    end
  end

  // the receiver never answers, so the pin is never pulled low
  always_ff @(posedge i_core_clk)
  begin
    o_single_wire_out <= 1'b0;
    o_single_wire_oe <= 1'b0;
  end

  // read data, latched in the wait cycle so it stands at the accept edge
  always_ff @(posedge i_core_clk)
  begin
    if (rst)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read && o_avs_waitrequest)
    begin
      o_avs_readdata <= 32'h0000_0000;
      case (wa)
        `OCL_ADDR_SECOND_CONFIG_REGISTER: o_avs_readdata[7:0] <= ram[0];
        `OCL_ADDR_SOFTWARE_CONTROL_REGISTER: o_avs_readdata[2:0] <= ram_source_select;
        `OCL_ADDR_OUTPUT_TIMER_REGISTER: o_avs_readdata[7:0] <= output_on_timer;
        `OCL_ADDR_STATUS:
        begin
          o_avs_readdata[`OCL_ST_OUT_EN] <= o_sensor_output_en;
          o_avs_readdata[`OCL_ST_STATE_LSB +: 3] <= st;
          o_avs_readdata[`OCL_ST_RAM_OK] <= ram_ok;
          o_avs_readdata[`OCL_ST_BANK_LSB +: 3] <= active_bank;
        end
        `OCL_ADDR_LINK: o_avs_readdata[7:0] <= lk_last;
        default:
        begin
          for (int n = 0; n < NPTR; n++)
            if (wa == 8'(`OCL_ADDR_PTR_BASE + 4 * n))
              o_avs_readdata[7:0] <= {ptr_done[n], 4'h0, ptr[n]};
          for (int i = 0; i < WORDS; i++)
            if (wa == 8'(`OCL_ADDR_RAM_BASE + 4 * i))
              o_avs_readdata[7:0] <= ram[i];
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* bench/ocl_loader_assertions.sv */
// ocl_loader_assertions.sv: port-level checker for the configuration loader.
// assumes: bound to ocl_loader; one clock domain, sync reset or supply drop.
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"
module ocl_loader_checker #(
  parameter int TICK_CYCLES = 200000
) (
  // clock, reset and supply
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_supply_ok,
  // register bus
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // pin and output gate
  input wire logic i_single_wire_pin,
  input wire logic o_single_wire_out,
  input wire logic o_single_wire_oe,
  input wire logic o_sensor_output_en
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst || !i_supply_ok);
  logic [31:0] since_wr;
  logic last_zero;
  sequence s_req_waiting;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_timer_set;
    i_avs_write && !o_avs_waitrequest && i_avs_address == `OCL_ADDR_OUTPUT_TIMER_REGISTER && i_avs_byteenable[0]
      && i_avs_writedata[7:0] != 8'h00;
  endsequence
  // cycles since the last accepted timer write; a zero write may end the count at once
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || !i_supply_ok)
    begin
      since_wr <= 32'h4000_0000;
      last_zero <= 1'b0;
    end
    else if (i_avs_write && !o_avs_waitrequest && i_avs_address == `OCL_ADDR_OUTPUT_TIMER_REGISTER && i_avs_byteenable[0])
    begin
      since_wr <= 32'h0;
      last_zero <= (i_avs_writedata[7:0] == 8'h00);
    end
    else if (since_wr < 32'h4000_0000)
      since_wr <= since_wr + 32'h1;
  end
  wait_answer_a: assert property (s_req_waiting |=> !o_avs_waitrequest)
    else $error("waitrequest did not drop one cycle after a request");
  wait_single_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
    else $error("waitrequest low without a request");
  read_hold_a: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("readdata changed without a read");
  reset_quiet_a: assert property (disable iff (1'b0)
    (i_sys_rst || !i_supply_ok) |=> !o_sensor_output_en && o_avs_waitrequest && o_avs_readdata == 32'h0)
    else $error("outputs not at reset values during reset");
  line_release_a: assert property (!o_single_wire_oe && !o_single_wire_out)
    else $error("receiver drives the shared line");
  timer_on_a: assert property (s_timer_set |-> ##[1:2] o_sensor_output_en)
    else $error("output not enabled after non-zero timer write");
  fell_late_a: assert property ($fell(o_sensor_output_en) |-> last_zero || since_wr >= 9 * TICK_CYCLES)
    else $error("output disabled before the first timer step");
endmodule
bind ocl_loader ocl_loader_checker #(.TICK_CYCLES(TICK_CYCLES)) u_ocl_loader_checker (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_supply_ok(i_supply_ok),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_single_wire_pin(i_single_wire_pin), .o_single_wire_out(o_single_wire_out),
  .o_single_wire_oe(o_single_wire_oe), .o_sensor_output_en(o_sensor_output_en));
`default_nettype wire

/* bench/ocl_link_master.sv */
// ocl_link_master.sv: behavioural calibration controller on the single wire.
// assumes: line has a pull-up; tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"
module ocl_link_master #(
  parameter int BIT_CYCLES = 40
) (
  // clock
  input wire logic i_core_clk,
  // line drive, high when released
  output var logic o_line
);
  initial o_line = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_line <= frame[i];
      repeat (BIT_CYCLES) @(posedge i_core_clk);
    end
  endtask
  // one rate for the whole transaction, opened by the rate-setting byte
  task automatic send_txn(input logic [7:0] cmd, input logic [7:0] data);
    send_byte(`OCL_INIT_BYTE);
    send_byte(cmd);
    send_byte(data);
  endtask
endmodule
`default_nettype wire

/* bench/test_otp_config_loader_output_gate.sv */
// test_otp_config_loader_output_gate.sv: self-checking bench for the loader.
// assumes: time base shortened to 20 cycles a tick; link bit period 40 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "ocl_map.svh"
module test_otp_config_loader_output_gate;
  localparam int TICK = 20;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_supply_ok = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pin, link_line, sw_out, sw_oe, out_en;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  // open-drain wire with pull-up
  assign pin = link_line & ~(sw_oe & ~sw_out);
  ocl_loader #(.TICK_CYCLES(TICK)) u_ocl_loader (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_supply_ok(i_supply_ok),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_single_wire_pin(pin), .o_single_wire_out(sw_out), .o_single_wire_oe(sw_oe),
    .o_sensor_output_en(out_en));
  ocl_link_master #(.BIT_CYCLES(40)) u_ocl_link_master (.i_core_clk(i_core_clk), .o_line(link_line));
  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge i_core_clk);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // no wait count is assumed; a hung access is ended by the watchdog
    do
    begin
      @(posedge i_core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    comparisons++;
    if (q !== exp)
    begin
      miscompares++;
      $display("Error reg %h expected %h seen %h", a, exp, q);
    end
  endtask
  task automatic check_out(input logic exp);
    comparisons++;
    if (out_en !== exp)
    begin
      miscompares++;
      $display("Error sensor_output_en expected %b seen %b", exp, out_en);
    end
  endtask
  task automatic power_cycle;
    i_supply_ok <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    check_out(1'b0);
    i_supply_ok <= 1'b1;
    @(posedge i_core_clk);
  endtask
  // nothing programmed: load fails, output stays off
  task automatic scen_empty_por;
    ticks(30);
    check_out(1'b0);
    check_reg(`OCL_ADDR_STATUS, 32'h08);
    check_reg(8'h30, 32'h0);
    check_reg(`OCL_ADDR_PTR_BASE + 8'h0C, 32'h0);
    // a timer write without its low byte lane is refused
    avs_byteenable <= 4'hE;
    wr(`OCL_ADDR_OUTPUT_TIMER_REGISTER, 32'h5);
    avs_byteenable <= 4'hF;
    check_reg(`OCL_ADDR_OUTPUT_TIMER_REGISTER, 32'h0);
    // link switched off in the config word: a timer write over it is ignored
    wr(`OCL_ADDR_SECOND_CONFIG_REGISTER, 32'h1);
    u_ocl_link_master.send_txn(8'h02, 8'h03);
    check_out(1'b0);
    check_reg(`OCL_ADDR_OUTPUT_TIMER_REGISTER, 32'h0);
    wr(`OCL_ADDR_SECOND_CONFIG_REGISTER, 32'h0);
  endtask
  task automatic scen_link_timeout;
    u_ocl_link_master.send_byte(`OCL_INIT_BYTE);
    u_ocl_link_master.send_byte(8'h02);
    ticks(30);
    u_ocl_link_master.send_byte(8'h01);
    check_reg(`OCL_ADDR_OUTPUT_TIMER_REGISTER, 32'h0);
    check_out(1'b0);
    ticks(30);
    // the timeout runs from one completed byte to the next and a byte lasts 20 ticks here
    u_ocl_link_master.send_byte(`OCL_INIT_BYTE);
    ticks(4);
    u_ocl_link_master.send_byte(8'h02);
    ticks(4);
    u_ocl_link_master.send_byte(8'h04);
    ticks(1);
    check_out(1'b1);
    ticks(50);
    check_out(1'b0);
  endtask
  task automatic scen_bank_load;
    wr(`OCL_ADDR_OTP_PROG, 32'h0000_07FF);
    wr(`OCL_ADDR_OTP_PROG, 32'h0000_0700);
    wr(`OCL_ADDR_OTP_PROG, 32'h0001_0002);
    wr(`OCL_ADDR_OTP_PROG, 32'h0001_07FD);
    wr(`OCL_ADDR_PTR_BASE + 8'h04, 32'h2);
    check_reg(`OCL_ADDR_PTR_BASE + 8'h04, 32'h0);
    wr(`OCL_ADDR_PTR_BASE, 32'h1);
    check_reg(`OCL_ADDR_PTR_BASE, 32'h81);
    power_cycle();
    ticks(20);
    check_out(1'b0);
    ticks(7);
    check_out(1'b1);
    check_reg(`OCL_ADDR_RAM_BASE + 8'h1C, 32'hFF);
  endtask
  task automatic scen_instant;
    wr(`OCL_ADDR_PTR_BASE + 8'h04, 32'h2);
    check_reg(`OCL_ADDR_PTR_BASE + 8'h04, 32'h82);
    power_cycle();
    ticks(3);
    check_out(1'b1);
    check_reg(`OCL_ADDR_RAM_BASE + 8'h1C, 32'hFD);
    check_reg(`OCL_ADDR_RAM_BASE, 32'h02);
  endtask
  // link traffic in the middle of the watch pushes its expiry out
  task automatic scen_watch;
    wr(`OCL_ADDR_OUTPUT_TIMER_REGISTER, 32'h2);
    @(posedge i_core_clk);
    check_out(1'b1);
    ticks(12);
    check_reg(`OCL_ADDR_OUTPUT_TIMER_REGISTER, 32'h1);
    ticks(5);
    check_out(1'b1);
    ticks(6);
    check_out(1'b0);
    ticks(500);
    u_ocl_link_master.send_txn(8'h01, 8'h01);
    ticks(985);
    check_out(1'b0);
    ticks(20);
    check_out(1'b1);
    check_reg(`OCL_ADDR_SOFTWARE_CONTROL_REGISTER, 32'h1);
    check_reg(`OCL_ADDR_RAM_BASE + 8'h1C, 32'hFF);
  endtask
  task automatic scen_recover;
    wr(`OCL_ADDR_RAM_BASE + 8'h1C, 32'h0);
    wr(`OCL_ADDR_OUTPUT_TIMER_REGISTER, 32'h1);
    ticks(12);
    check_out(1'b0);
    ticks(1005);
    check_out(1'b1);
    check_reg(`OCL_ADDR_RAM_BASE + 8'h1C, 32'hFD);
  endtask
  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    scen_empty_por();
    scen_link_timeout();
    scen_bank_load();
    scen_instant();
    scen_watch();
    scen_recover();
    tally_and_finish();
  end
  // the sequence needs about 60000 cycles
  initial
  begin
    repeat (90000) @(posedge i_core_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
